/* File: core/pm_cap_pkg.sv */
package pm_cap_pkg;

  // ****************************************************************
  // structure layout: pointer register address, byte offsets from the capability base and bit positions
  // ****************************************************************
  localparam logic [7:0] CAP_PTR_ADDR      = 8'h34;
  localparam logic [1:0] OFS_CAPABILITY_IDENTIFIER        = 2'h0;
  localparam logic [1:0] OFS_NEXT_PTR      = 2'h1;
  localparam logic [1:0] OFS_PM_WORD       = 2'h2;
  localparam int         CAPABILITY_IDENTIFIER_LSB        = 0;
  localparam int         NEXT_PTR_LSB      = 8;
  localparam int         PM_WORD_LSB       = 16;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  CAPABILITY_IDENTIFIER = 8'h01;
  localparam logic [7:0]  NEXT_PTR_FULL_SPEED   = 8'h00;
  localparam logic [7:0]  NEXT_PTR_HIGH_SPEED   = 8'hE4;
  localparam logic [15:0] PM_WORD_COMMON        = 16'hD282;
  localparam logic [15:0] PM_WORD_HS_BITS       = 16'h2C00;
  localparam logic [2:0]  AUX_CODE_DEFAULT      = 3'h2;
  localparam logic [2:0]  AUX_CODE_NONE         = 3'h0;
  localparam logic [2:0]  PM_REVISION_CODE      = 3'h2;

  // ****************************************************************
  // field positions in the capabilities word
  // ****************************************************************
  localparam int WAKE_STATE_SUPPORT_LSB = 11;
  localparam int WAKE_STATE_SUPPORT_MSB = 15;
  localparam int WAKE_COLD_BIT          = 15;
  localparam int STATE_TWO_SUPPORT_BIT  = 10;
  localparam int STATE_ONE_SUPPORT_BIT  = 9;
  localparam int AUX_CURRENT_LSB        = 6;
  localparam int AUX_CURRENT_MSB        = 8;
  localparam int DEVICE_INIT_BIT        = 5;
  localparam int RESERVED_BIT           = 4;
  localparam int WAKE_NEEDS_BUS_CLOCK_BIT = 3;
  localparam int PM_REVISION_LSB        = 0;
  localparam int PM_REVISION_MSB        = 2;

  localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

  // config answer sequencing
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_ANSWER
  } cfg_state_t;

endpackage : pm_cap_pkg

/* File: core/pm_cap_regs.sv */
`timescale 1ns/10ps
// power-management capability entry of one host function
module pm_cap_regs #(
  parameter bit         HIGH_SPEED    = 1'b0,
  parameter bit         DATA_REG_IMPL = 1'b0,
  parameter logic [2:0] AUX_CODE      = pm_cap_pkg::AUX_CODE_DEFAULT,
  parameter logic [7:0] CAP_BASE      = 8'h50
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // configuration access from the host bridge
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  // configuration answer
  output logic             cfg_ack_q,
  output logic             cfg_hit_q,
  output logic [31:0]      cfg_rdata_q,
  // capability contents seen by the function
  output logic [7:0]       next_capability_offset_q,
  output logic [15:0]      power_capabilities_word_q
);
  import pm_cap_pkg::*;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  // the entry must sit dword aligned above the standard header
  if (CAP_BASE[1:0] != 2'h0 || CAP_BASE < 8'h40) begin : g_bad_base
    $error("capability base must be dword aligned and above 3Fh");
  end

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic [5:0] dword_index(input logic [7:0] addr);
    dword_index = addr[7:2];
  endfunction : dword_index

  function automatic logic [31:0] entry_dword(input logic [7:0] nxt,
                                              input logic [15:0] pw);
    entry_dword = {pw, nxt, CAPABILITY_IDENTIFIER};
  endfunction : entry_dword

  // ****************************************************************
  // fixed contents
  // ****************************************************************
  localparam logic [7:0] NEXT_RESET = HIGH_SPEED ? NEXT_PTR_HIGH_SPEED
                                                 : NEXT_PTR_FULL_SPEED;

  wire logic [15:0] pm_word_value;

  pm_cap_word_builder #(
    .HIGH_SPEED    (HIGH_SPEED),
    .DATA_REG_IMPL (DATA_REG_IMPL),
    .AUX_CODE      (AUX_CODE)
  ) u_word (
    .pm_word (pm_word_value)
  );

  // the word is a constant; holding it in flops keeps outputs registered
  // and any configuration write simply never reaches these flops
  localparam logic [15:0] PM_RESET =
    {HIGH_SPEED ? (PM_WORD_COMMON[15:9] | PM_WORD_HS_BITS[15:9])
                : PM_WORD_COMMON[15:9],
     (DATA_REG_IMPL || !PM_WORD_COMMON[WAKE_COLD_BIT]) ? AUX_CODE_NONE
                                                        : AUX_CODE,
     PM_WORD_COMMON[5:3] & 3'h1,
     PM_REVISION_CODE};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      next_capability_offset_q  <= NEXT_RESET;
      power_capabilities_word_q <= PM_RESET;
    end else begin
      next_capability_offset_q  <= NEXT_RESET;
      power_capabilities_word_q <= pm_word_value;
    end
  end

  // ****************************************************************
  // configuration decode
  // ****************************************************************
  wire logic        hit_entry;
  wire logic        hit_ptr;
  wire logic        take_req;
  wire logic [31:0] ptr_dword;
  wire logic [31:0] read_value;
  cfg_state_t       state_q;
  cfg_state_t       state_d;

  assign hit_entry  = dword_index(cfg_addr) == dword_index(CAP_BASE);
  assign hit_ptr    = dword_index(cfg_addr) == dword_index(CAP_PTR_ADDR);
  assign take_req   = cfg_req && state_q == ST_IDLE;
  // the pointer register at 34h lists this entry first
  assign ptr_dword  = {24'h00_0000, CAP_BASE};
  // reads return the whole dword; byte enables do not mask read data
  assign read_value = hit_entry ? entry_dword(next_capability_offset_q,
                                              power_capabilities_word_q)
                    : hit_ptr   ? ptr_dword
                    : READ_ZERO;

  // one answer per request; a request during the answer is dropped
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (cfg_req) begin
          state_d = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // answer registers
  // ****************************************************************
  // writes complete normally with zero read data and no side effect
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      cfg_ack_q   <= 1'b0;
      cfg_hit_q   <= 1'b0;
      cfg_rdata_q <= READ_ZERO;
    end else begin
      state_q     <= state_d;
      cfg_ack_q   <= take_req;
      cfg_hit_q   <= take_req && (hit_entry || hit_ptr);
      cfg_rdata_q <= (take_req && !cfg_we) ? read_value : READ_ZERO;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  wire logic unused_inputs;
  assign unused_inputs = ^{cfg_be, cfg_wdata};

  AST_NEXT_PTR_VALUE: assert property (
    next_capability_offset_q == NEXT_RESET)
    else $error("next pointer differs from its fixed value");

  AST_NEXT_PTR_FUNC: assert property (
    next_capability_offset_q == (HIGH_SPEED ? 8'hE4 : 8'h00))
    else $error("next pointer wrong for this function");

  AST_WORD_STABLE: assert property (
    cfg_req && cfg_we |=> $stable(power_capabilities_word_q) [*2])
    else $error("capabilities word changed after a write");

  AST_WAKE_FLAGS: assert property (
    power_capabilities_word_q[15:11] ==
      (HIGH_SPEED ? 5'h1F : 5'h1A))
    else $error("wake support flags wrong");

  AST_HS_BITS: assert property (
    {power_capabilities_word_q[13], power_capabilities_word_q[11],
     power_capabilities_word_q[10]} == {3{HIGH_SPEED}})
    else $error("function-specific bits wrong");

  AST_STATE_SUPPORT: assert property (
    power_capabilities_word_q[STATE_ONE_SUPPORT_BIT] &&
    power_capabilities_word_q[STATE_TWO_SUPPORT_BIT] == HIGH_SPEED)
    else $error("state support bits wrong");

  AST_AUX_ZERO: assert property (
    (DATA_REG_IMPL || !power_capabilities_word_q[WAKE_COLD_BIT]) |->
      power_capabilities_word_q[8:6] == 3'h0)
    else $error("aux current not zero");

  AST_AUX_CODE: assert property (
    (!DATA_REG_IMPL && power_capabilities_word_q[WAKE_COLD_BIT]) |->
      power_capabilities_word_q[8:6] == AUX_CODE)
    else $error("aux current code wrong");

  AST_DEVICE_INIT: assert property (
    !power_capabilities_word_q[DEVICE_INIT_BIT])
    else $error("device init flag set");

  AST_WAKE_CLOCK: assert property (
    !power_capabilities_word_q[WAKE_NEEDS_BUS_CLOCK_BIT])
    else $error("wake clock bit set");

  AST_REVISION: assert property (
    power_capabilities_word_q[2:0] == 3'h2)
    else $error("revision field wrong");

  AST_CAPABILITY_IDENTIFIER_READ: assert property (
    take_req && !cfg_we && hit_entry |=>
      cfg_ack_q && cfg_rdata_q[7:0] == 8'h01 &&
      cfg_rdata_q[31:16] == power_capabilities_word_q)
    else $error("entry read returned wrong data");

  AST_WRITE_ACK: assert property (
    take_req && cfg_we |=> cfg_ack_q && cfg_rdata_q == 32'h0 ##1
      !cfg_ack_q)
    else $error("write not answered in one cycle");

  AST_RESERVED: assert property (
    !power_capabilities_word_q[RESERVED_BIT])
    else $error("reserved bit set");

  // ****************************************************************
  // answer protocol checks
  // ****************************************************************
  // one taken request gives exactly one answer one cycle later
  AST_ACK_AFTER_TAKE: assert property (
    take_req |=> cfg_ack_q)
    else $error("taken request not answered");

  AST_ACK_NEEDS_TAKE: assert property (
    !take_req |=> !cfg_ack_q)
    else $error("answer without a taken request");

  AST_ACK_ONE_CYCLE: assert property (
    cfg_ack_q |=> !cfg_ack_q)
    else $error("answer held longer than one cycle");

  // a request while the answer stands is refused, not queued
  AST_BUSY_DROP: assert property (
    cfg_req && state_q == ST_ANSWER |=> !cfg_ack_q)
    else $error("request during answer was taken");

  AST_STATE_MATCH: assert property (
    (state_q == ST_ANSWER) == cfg_ack_q)
    else $error("answer state and answer flag disagree");

  // data and hit must read zero whenever no answer stands
  AST_QUIET_DATA: assert property (
    !cfg_ack_q |-> cfg_rdata_q == READ_ZERO && !cfg_hit_q)
    else $error("read data or hit outside an answer");

  // ****************************************************************
  // read data checks
  // ****************************************************************
  AST_ENTRY_HIT: assert property (
    take_req && hit_entry |=> cfg_hit_q)
    else $error("entry access not flagged as hit");

  AST_ENTRY_NEXT: assert property (
    take_req && !cfg_we && hit_entry |=>
      cfg_rdata_q[15:8] == (HIGH_SPEED ? 8'hE4 : 8'h00))
    else $error("entry read returned wrong next pointer");

  AST_PTR_READ: assert property (
    take_req && !cfg_we && hit_ptr |=>
      cfg_hit_q && cfg_rdata_q == {24'h00_0000, CAP_BASE})
    else $error("pointer read returned wrong offset");

  // unmapped dwords answer so the host never waits on this block
  AST_UNMAPPED: assert property (
    take_req && !hit_entry && !hit_ptr |=>
      cfg_ack_q && !cfg_hit_q && cfg_rdata_q == READ_ZERO)
    else $error("unmapped access answered wrongly");

  // ****************************************************************
  // register content checks
  // ****************************************************************
  // the running word must equal the value loaded in reset
  AST_WORD_RESET_MATCH: assert property (
    power_capabilities_word_q == PM_RESET)
    else $error("capabilities word departs from its reset value");

  AST_WORD_CONST: assert property (
    $stable(power_capabilities_word_q))
    else $error("capabilities word changed");

  AST_NEXT_CONST: assert property (
    $stable(next_capability_offset_q))
    else $error("next pointer changed");

  // a write anywhere leaves both registers at their fixed values
  AST_WRITE_NO_EFFECT: assert property (
    take_req && cfg_we |=> power_capabilities_word_q == PM_RESET &&
      next_capability_offset_q == NEXT_RESET)
    else $error("write changed a register");

  // software walks the list by dwords, so the pointer stays aligned
  AST_NEXT_ALIGNED: assert property (
    next_capability_offset_q[1:0] == 2'h0)
    else $error("next pointer not dword aligned");

  // ****************************************************************
  // scenario coverage
  // ****************************************************************

  COV_ENTRY_READ: cover property (
    take_req && !cfg_we && hit_entry ##1 cfg_ack_q);
  COV_PTR_READ: cover property (
    take_req && !cfg_we && hit_ptr ##1 cfg_ack_q);
  COV_WRITE: cover property (take_req && cfg_we ##1 cfg_ack_q);
  COV_BUSY_DROP: cover property (cfg_req && state_q == ST_ANSWER);
  COV_BACK_TO_BACK: cover property (take_req ##2 take_req);

endmodule : pm_cap_regs

/* File: core/pm_cap_word_builder.sv */
`timescale 1ns/10ps
// assembles the capabilities word from the function's options
module pm_cap_word_builder #(
  parameter bit         HIGH_SPEED    = 1'b0,
  parameter bit         DATA_REG_IMPL = 1'b0,
  parameter logic [2:0] AUX_CODE      = pm_cap_pkg::AUX_CODE_DEFAULT
) (
  // assembled word
  output wire logic [15:0] pm_word
);
  import pm_cap_pkg::*;

  // ****************************************************************
  // field assembly
  // ****************************************************************
  wire logic [15:0] base_word;
  wire logic        cold_wake;
  wire logic        any_wake;
  wire logic [2:0]  aux_field;

  // high-speed function adds D0 wake, D2 wake and D2 support
  assign base_word = HIGH_SPEED ? (PM_WORD_COMMON | PM_WORD_HS_BITS)
                                : PM_WORD_COMMON;
  assign cold_wake = base_word[WAKE_COLD_BIT];
  assign any_wake  = |base_word[WAKE_STATE_SUPPORT_MSB:
                                WAKE_STATE_SUPPORT_LSB];
  // data register takes precedence; no cold wake means no aux draw
  assign aux_field = (DATA_REG_IMPL || !cold_wake) ? AUX_CODE_NONE
                                                   : AUX_CODE;

  // reserved and init bits are forced low, clock bit is gated by any wake support, revision fixed
  assign pm_word = {base_word[15:9],
                    aux_field,
                    1'b0,
                    1'b0,
                    base_word[WAKE_NEEDS_BUS_CLOCK_BIT] & any_wake,
                    PM_REVISION_CODE};

endmodule : pm_cap_word_builder

/* File: verif/cfg_host_model.sv */
`timescale 1ns/10ps
// host bridge side: issues configuration requests held for len clock edges
module cfg_host_model (
  // clock
  input  wire logic        core_clk,
  // configuration request
  output logic             cfg_req,
  output logic             cfg_we,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata
);
  initial begin
    cfg_req   = 1'b0;
    cfg_we    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0;
  end

  // qualifiers are inverted once released, so a late sampler sees junk
  task automatic access(input logic we, input logic [7:0] addr,
                        input logic [3:0] be, input logic [31:0] wd,
                        input int len);
    @(negedge core_clk);
    cfg_req   = 1'b1;
    cfg_we    = we;
    cfg_addr  = addr;
    cfg_be    = be;
    cfg_wdata = wd;
    repeat (len) @(negedge core_clk);
    cfg_req   = 1'b0;
    cfg_we    = ~we;
    cfg_addr  = ~addr;
    cfg_be    = ~be;
    cfg_wdata = ~wd;
  endtask : access
endmodule : cfg_host_model

/* File: verif/testbench.sv */
`timescale 1ns/10ps
// self-checking bench: high-speed and full-speed entries side by side
module testbench;
  import pm_cap_pkg::*;
  localparam logic [7:0] CB = 8'h60; // off the default base on purpose
  logic        core_clk;
  logic        rst;
  logic        cfg_req;
  logic        cfg_we;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata;
  logic        ack_hs;
  logic        ack_fs;
  logic        hit_hs;
  logic        hit_fs;
  logic [31:0] rd_hs;
  logic [31:0] rd_fs;
  logic [7:0]  nx_hs;
  logic [7:0]  nx_fs;
  logic [15:0] pw_hs;
  logic [15:0] pw_fs;
  logic [67:0] exp_q[$];
  logic [67:0] note;
  logic [67:0] seen;
  logic [15:0] pw_dr;
  int          fail_count;
  int          n_tests;
  int          cycles;

  cfg_host_model host_u (.core_clk(core_clk), .cfg_req(cfg_req),
    .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata));
  pm_cap_regs #(.HIGH_SPEED(1'b1), .CAP_BASE(CB)) dut_u (
    .core_clk(core_clk), .rst(rst), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ack_q(ack_hs), .cfg_hit_q(hit_hs), .cfg_rdata_q(rd_hs),
    .next_capability_offset_q(nx_hs), .power_capabilities_word_q(pw_hs));
  pm_cap_regs #(.HIGH_SPEED(1'b0), .CAP_BASE(CB)) fs_u (
    .core_clk(core_clk), .rst(rst), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ack_q(ack_fs), .cfg_hit_q(hit_fs), .cfg_rdata_q(rd_fs),
    .next_capability_offset_q(nx_fs), .power_capabilities_word_q(pw_fs));
  // data register variant: aux current must read zero
  pm_cap_regs #(.HIGH_SPEED(1'b1), .DATA_REG_IMPL(1'b1), .CAP_BASE(CB))
    dr_u (
    .core_clk(core_clk), .rst(rst), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ack_q(), .cfg_hit_q(), .cfg_rdata_q(),
    .next_capability_offset_q(), .power_capabilities_word_q(pw_dr));

  assign seen = {ack_hs, ack_fs, hit_hs, hit_fs, rd_hs, rd_fs};

  // ****************************************************************
  // clock, expectations and reporting
  // ****************************************************************
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  // capabilities word bit by bit; hs sets bits 13, 11 and 10
  function automatic logic [15:0] exp_word(input logic hs);
    return {2'b11, hs, 1'b1, hs, hs, 1'b1, 3'b010, 3'b000, 3'b010};
  endfunction : exp_word

  // answer note: two acks, two hits, two read words
  function automatic logic [67:0] exp_ans(input logic we,
                                          input logic [7:0] a);
    logic        h34;
    logic        hcb;
    logic [31:0] dh;
    logic [31:0] df;
    h34 = ({a[7:2], 2'b00} == 8'h34);
    hcb = ({a[7:2], 2'b00} == CB);
    dh = we ? 32'h0 : h34 ? {24'h0, CB} :
         hcb ? {exp_word(1'b1), 8'hE4, 8'h01} : 32'h0;
    df = we ? 32'h0 : h34 ? {24'h0, CB} :
         hcb ? {exp_word(1'b0), 8'h00, 8'h01} : 32'h0;
    return {2'b11, h34 | hcb, h34 | hcb, dh, df};
  endfunction : exp_ans

  task automatic err(input string m);
    fail_count++;
    $display("Error at %0t: %s", $time, m);
  endtask : err

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk_lvl;
    n_tests += 3;
    if (pw_dr !== (exp_word(1'b1) & 16'hFE3F)) err("dr aux field");
    if ({nx_hs, pw_hs} !== {8'hE4, exp_word(1'b1)}) err("hs fields");
    if ({nx_fs, pw_fs} !== {8'h00, exp_word(1'b0)}) err("fs fields");
  endtask : chk_lvl

  // a held request covers len edges; the first one and every second one after it are taken
  task automatic go(input logic we, input logic [7:0] a, input int len);
    exp_q.push_back(exp_ans(we, a));
    host_u.access(we, a, 4'($urandom), $urandom, len);
  endtask : go

  // answers are matched oldest first; data and hit stay low between
  always @(posedge core_clk) begin
    if (rst === 1'b0) begin
      if (ack_hs === 1'b1 || ack_fs === 1'b1) begin
        n_tests++;
        if (exp_q.size() == 0) begin
          err("answer without request");
        end else begin
          note = exp_q.pop_front();
          if (seen !== note) err("answer mismatch");
        end
      end else if (rd_hs !== 32'h0 || rd_fs !== 32'h0 ||
                   hit_hs !== 1'b0 || hit_fs !== 1'b0) begin
        err("read data outside answer");
      end
    end
  end

  // hang guard, generous against the roughly 100 cycles used
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err("timeout");
      stop_test();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [7:0] a;
    int         sel;
    fail_count = 0;
    n_tests = 0;
    cycles = 0;
    void'($urandom(32'h18c545fa));
    rst = 1'b1;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    chk_lvl();
    go(1'b0, CB, 1);
    go(1'b1, CB + 8'h02, 1);
    go(1'b1, 8'h34, 1);
    go(1'b0, 8'h34, 1);
    go(1'b0, CB + 8'h01, 2);
    // random mix of pointer, entry and unmapped dwords, reads and writes
    for (int i = 0; i < 40; i++) begin
      a = 8'($urandom);
      sel = $urandom_range(0, 2);
      if (sel == 0) a = {6'h0D, a[1:0]};
      if (sel == 1) a = {CB[7:2], a[1:0]};
      go(1'($urandom), a, 1);
    end
    chk_lvl();
    // reset again in mid-run, values must come back unchanged
    @(negedge core_clk);
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    chk_lvl();
    go(1'b0, CB, 1);
    repeat (4) @(negedge core_clk);
    n_tests++;
    if (exp_q.size() != 0) err("missing answers");
    stop_test();
  end
endmodule : testbench
